/* verilog/port_pin_map.vh */
// constants for the port pin function multiplexer
`ifndef PORT_PIN_MAP_VH
`define PORT_PIN_MAP_VH
// register offsets
`define PORT_C_ALT_CONFIG_ADDR  16'he671
`define PORT_E_ALT_CONFIG_ADDR  16'he672
`define WAKEUP_CTRL_ADDR        16'he682
`define PIN_STATUS_ADDR         16'he6f0
// reset values
`define ALT_CONFIG_RESET        8'h00
`define WAKEUP_CTRL_RESET       8'h00
// field positions
`define PORT_E_T0_BIT           0
`define PORT_E_T1_BIT           1
`define WAKEUP_POL_BIT          4
// interface config value that keeps ports b/d as ports; any other value hands port b to the data bus, and port d too when endpoint_fifo_config is set
`define IFC_PORTS               2'h0
`endif

/* verilog/sync2.v */
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ns
module sync2 #(
    parameter W = 8
) (
    // clock and reset
    input  wire         ref_clk,
    input  wire         rst,
    // async in, synced out
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_q;

    // first stage read only by the second
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // sync2

/* verilog/port_pin_function_mux.v */
// port pin function multiplexer with alternate-function selection
//==========================================================
//==========================================================
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "port_pin_map.vh"
module port_pin_function_mux (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // register port
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // configuration from elsewhere in the chip
    input  wire [1:0]  interface_config_select,
    input  wire        endpoint_fifo_config,
    // port latches and directions from the cpu
    input  wire [7:0]  port_b_latch,
    input  wire [7:0]  port_b_dir,
    input  wire [7:0]  port_c_latch,
    input  wire [7:0]  port_c_dir,
    input  wire [7:0]  port_d_latch,
    input  wire [7:0]  port_d_dir,
    input  wire [1:0]  port_e_latch,
    input  wire [1:0]  port_e_dir,
    // data bus and waveform engine side
    input  wire [15:0] fifo_data_bus_out,
    input  wire        fifo_data_bus_drive,
    output reg  [15:0] fifo_data_bus_in,
    input  wire [7:0]  waveform_address_out,
    // timer events from the cpu core
    input  wire        timer0_overflow,
    input  wire        timer0_low_overflow,
    input  wire        timer0_split_mode,
    input  wire        timer1_overflow,
    input  wire        timer1_low_overflow,
    input  wire        timer1_split_mode,
    input  wire        timer0_counter_timer_select,
    input  wire        timer1_counter_timer_select,
    output reg         timer0_count_tick,
    output reg         timer1_count_tick,
    // serial engines
    input  wire        serial0_sync_mode,
    input  wire        serial0_shift_clk,
    input  wire        serial0_data_out,
    input  wire        serial1_sync_mode,
    input  wire        serial1_shift_clk,
    input  wire        serial1_data_out,
    output reg         serial0_rx_data,
    output reg         serial1_rx_data,
    // external memory strobes from the cpu
    input  wire        mem_cs_req,
    input  wire        mem_wr_req,
    input  wire        mem_rd_req,
    input  wire        mem_oe_req,
    // suspend control
    input  wire        suspend_req,
    output reg         suspended,
    output reg         osc_start,
    output reg         wakeup_irq,
    // port b pins
    input  wire [7:0]  port_b_pin_i,
    output reg  [7:0]  port_b_pin_o,
    output reg  [7:0]  port_b_pin_oe,
    // port c pins
    input  wire [7:0]  port_c_pin_i,
    output reg  [7:0]  port_c_pin_o,
    output reg  [7:0]  port_c_pin_oe,
    // port d pins
    input  wire [7:0]  port_d_pin_i,
    output reg  [7:0]  port_d_pin_o,
    output reg  [7:0]  port_d_pin_oe,
    // port e pins
    input  wire [1:0]  port_e_pin_i,
    output reg  [1:0]  port_e_pin_o,
    output reg  [1:0]  port_e_pin_oe,
    // dedicated pins
    input  wire        timer0_count_input,
    input  wire        timer1_count_input,
    input  wire        serial0_rx_pin,
    input  wire        serial1_rx_pin,
    input  wire        wakeup_pin,
    output reg         serial0_tx_pin,
    output reg         serial1_tx_pin,
    output reg         mem_cs_n,
    output reg         mem_wr_n,
    output reg         mem_rd_n,
    output reg         mem_oe_n,
    output reg         port_b_is_bus,
    output reg         port_d_is_bus
);

    //==========================================================
    // pin synchronisers
    //==========================================================
    wire [7:0]  b_in_s;
    wire [7:0]  d_in_s;
    wire [4:0]  misc_s;

    sync2 #(.W(8)) u_sync_b (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (port_b_pin_i),
        .dout    (b_in_s)
    );

    sync2 #(.W(8)) u_sync_d (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (port_d_pin_i),
        .dout    (d_in_s)
    );

    // c and e inputs are only consumed by the cpu read path outside
    // rx pins pass inverted so the cleared stages read as an idle high
    // line; a plain copy would dip low after reset like a false start bit
    sync2 #(.W(5)) u_sync_misc (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     ({wakeup_pin, ~serial1_rx_pin, ~serial0_rx_pin,
                   timer1_count_input, timer0_count_input}),
        .dout    (misc_s)
    );

    //==========================================================
    // registers
    //==========================================================
    reg  [7:0]  port_c_alt_config_q;
    reg  [7:0]  port_e_alt_config_q;
    reg  [7:0]  wakeup_ctrl_q;
    reg  [1:0]  tin_prev_q;
    wire        wake_active;
    wire        sel_b;
    wire        sel_d;

    // the configuration bytes steer the muxes below
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_c_alt_config_q <= `ALT_CONFIG_RESET;
            port_e_alt_config_q <= `ALT_CONFIG_RESET;
            wakeup_ctrl_q       <= `WAKEUP_CTRL_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `PORT_C_ALT_CONFIG_ADDR: port_c_alt_config_q <= reg_wdata;
                `PORT_E_ALT_CONFIG_ADDR: port_e_alt_config_q <= reg_wdata;
                `WAKEUP_CTRL_ADDR:       wakeup_ctrl_q       <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, unmapped reads as zero
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PORT_C_ALT_CONFIG_ADDR: reg_rdata <= port_c_alt_config_q;
                `PORT_E_ALT_CONFIG_ADDR: reg_rdata <= port_e_alt_config_q;
                `WAKEUP_CTRL_ADDR:       reg_rdata <= wakeup_ctrl_q;
                `PIN_STATUS_ADDR:        reg_rdata <= {4'h0, suspended, wake_active,
                                                       port_d_is_bus, port_b_is_bus};
                default:                 reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    //==========================================================
    // function selection
    //==========================================================
    // any code other than the port code hands port b to the data bus
    assign sel_b = (interface_config_select != `IFC_PORTS);
    assign sel_d = sel_b & endpoint_fifo_config;
    // polarity bit 1 means active high wake pin
    assign wake_active = misc_s[4] ~^ wakeup_ctrl_q[`WAKEUP_POL_BIT];

    // timer overflow source, low byte counter in split mode
    wire t0_ovf = timer0_split_mode ? timer0_low_overflow : timer0_overflow;
    wire t1_ovf = timer1_split_mode ? timer1_low_overflow : timer1_overflow;

    // registered pin drive; alternate function wins over the latch
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    port_b_pin_o[i]  <= 1'b0;
                    port_b_pin_oe[i] <= 1'b0;
                    port_c_pin_o[i]  <= 1'b0;
                    port_c_pin_oe[i] <= 1'b0;
                    port_d_pin_o[i]  <= 1'b0;
                    port_d_pin_oe[i] <= 1'b0;
                end else begin
                    if (sel_b) begin
                        port_b_pin_o[i]  <= fifo_data_bus_out[i];
                        port_b_pin_oe[i] <= fifo_data_bus_drive;
                    end else begin
                        port_b_pin_o[i]  <= port_b_latch[i];
                        port_b_pin_oe[i] <= port_b_dir[i];
                    end
                    if (port_c_alt_config_q[i]) begin
                        port_c_pin_o[i]  <= waveform_address_out[i];
                        port_c_pin_oe[i] <= 1'b1;
                    end else begin
                        port_c_pin_o[i]  <= port_c_latch[i];
                        port_c_pin_oe[i] <= port_c_dir[i];
                    end
                    if (sel_d) begin
                        port_d_pin_o[i]  <= fifo_data_bus_out[i+8];
                        port_d_pin_oe[i] <= fifo_data_bus_drive;
                    end else begin
                        port_d_pin_o[i]  <= port_d_latch[i];
                        port_d_pin_oe[i] <= port_d_dir[i];
                    end
                end
            end
        end
    endgenerate

    // port e: registered overflow when the alternate bit is set, latch otherwise
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_e_pin_o  <= 2'b00;
            port_e_pin_oe <= 2'b00;
        end else begin
            if (port_e_alt_config_q[`PORT_E_T0_BIT]) begin
                port_e_pin_o[0]  <= t0_ovf;
                port_e_pin_oe[0] <= 1'b1;
            end else begin
                port_e_pin_o[0]  <= port_e_latch[0];
                port_e_pin_oe[0] <= port_e_dir[0];
            end
            if (port_e_alt_config_q[`PORT_E_T1_BIT]) begin
                port_e_pin_o[1]  <= t1_ovf;
                port_e_pin_oe[1] <= 1'b1;
            end else begin
                port_e_pin_o[1]  <= port_e_latch[1];
                port_e_pin_oe[1] <= port_e_dir[1];
            end
        end
    end

    //==========================================================
    // dedicated pins and bus returns
    //==========================================================
    // count ticks on rising edge of the synced pin, gated by select
    // history resets low to match idle-low count pins: no tick at start-up
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tin_prev_q        <= 2'b00;
            timer0_count_tick <= 1'b0;
            timer1_count_tick <= 1'b0;
        end else begin
            tin_prev_q        <= misc_s[1:0];
            timer0_count_tick <= timer0_counter_timer_select
                                 & misc_s[0] & ~tin_prev_q[0];
            timer1_count_tick <= timer1_counter_timer_select
                                 & misc_s[1] & ~tin_prev_q[1];
        end
    end

    // serial pins and returned bus data
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serial0_tx_pin   <= 1'b0;
            serial1_tx_pin   <= 1'b0;
            serial0_rx_data  <= 1'b1;
            serial1_rx_data  <= 1'b1;
            fifo_data_bus_in <= 16'h0000;
            port_b_is_bus    <= 1'b0;
            port_d_is_bus    <= 1'b0;
        end else begin
            serial0_tx_pin   <= serial0_sync_mode ? serial0_shift_clk
                                                  : serial0_data_out;
            serial1_tx_pin   <= serial1_sync_mode ? serial1_shift_clk
                                                  : serial1_data_out;
            serial0_rx_data  <= ~misc_s[2];
            serial1_rx_data  <= ~misc_s[3];
            // high byte reads zero when port d stays a port
            fifo_data_bus_in <= {sel_d ? d_in_s : 8'h00, sel_b ? b_in_s : 8'h00};
            port_b_is_bus    <= sel_b;
            port_d_is_bus    <= sel_d;
        end
    end

    // memory strobes, inverted requests, idle high
    // one cycle late, but each strobe is a flop output and cannot glitch
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_cs_n <= 1'b1;
            mem_wr_n <= 1'b1;
            mem_rd_n <= 1'b1;
            mem_oe_n <= 1'b1;
        end else begin
            mem_cs_n <= ~mem_cs_req;
            mem_wr_n <= ~mem_wr_req;
            mem_rd_n <= ~mem_rd_req;
            mem_oe_n <= ~mem_oe_req;
        end
    end

    // suspend state: held wake level blocks entry and ends suspend
    // entry also needs wake_active low, so wake beats a suspend request in the same cycle
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            suspended  <= 1'b0;
            osc_start  <= 1'b0;
            wakeup_irq <= 1'b0;
        end else begin
            osc_start  <= 1'b0;
            wakeup_irq <= 1'b0;
            if (suspended && wake_active) begin
                suspended  <= 1'b0;
                osc_start  <= 1'b1;
                wakeup_irq <= 1'b1;
            end else if (!suspended && suspend_req && !wake_active) begin
                suspended  <= 1'b1;
            end
        end
    end

endmodule // port_pin_function_mux

/* tb/port_pin_checker.sv */
// assertion checker for the port pin function multiplexer
`timescale 1ns/1ns
`include "port_pin_map.vh"
module port_pin_checker (
    // clock, reset and register writes
    input logic        ref_clk, rst, reg_wr,
    input logic [15:0] reg_addr, fifo_data_bus_out,
    input logic [7:0]  reg_wdata, waveform_address_out, port_c_latch, port_c_dir,
    // pins and their sources
    input logic [7:0]  port_c_pin_o, port_c_pin_oe, port_b_pin_o, port_b_pin_oe,
    input logic [1:0]  interface_config_select, port_e_pin_o, port_e_pin_oe,
    input logic        endpoint_fifo_config, fifo_data_bus_drive, port_b_is_bus, port_d_is_bus,
    input logic        timer0_overflow, timer0_low_overflow, timer0_split_mode,
    input logic        timer1_overflow, timer1_low_overflow, timer1_split_mode,
    input logic        timer0_counter_timer_select, timer0_count_tick, serial0_sync_mode,
    input logic        serial0_shift_clk, serial0_data_out, serial0_tx_pin,
    input logic        mem_cs_req, mem_wr_req, mem_rd_req, mem_oe_req,
    input logic        mem_cs_n, mem_wr_n, mem_rd_n, mem_oe_n
);
    logic [1:0] live_q;
    logic [7:0] cfg_c_q, cfg_e_q;
    wire  [7:0] bus_lo = fifo_data_bus_out[7:0];
    wire        live   = live_q[1];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // shadow config bytes; live masks edges whose past still sees reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            live_q  <= 2'h0;
            cfg_c_q <= 8'h00;
            cfg_e_q <= 8'h00;
        end else begin
            live_q <= live ? live_q : live_q + 2'h1;
            if (reg_wr && reg_addr == `PORT_C_ALT_CONFIG_ADDR)
                cfg_c_q <= reg_wdata;
            if (reg_wr && reg_addr == `PORT_E_ALT_CONFIG_ADDR)
                cfg_e_q <= reg_wdata;
        end
    end
    //==========================================================
    // pin ownership and timing
    chk_strobe_level: assert property (live |-> mem_cs_n == !$past(mem_cs_req)
        && mem_wr_n == !$past(mem_wr_req) && mem_oe_n == !$past(mem_oe_req))
        else $error("memory strobe is not the inverted request");
    chk_read_strobe: assert property (mem_rd_req ##1 !mem_rd_req |-> !mem_rd_n ##1 mem_rd_n)
        else $error("read strobe pulse wrong");
    chk_port_c_alt: assert property (live |-> port_c_pin_o ==
        ($past(cfg_c_q) & $past(waveform_address_out) | ~$past(cfg_c_q) & $past(port_c_latch))
        && port_c_pin_oe == ($past(cfg_c_q) | $past(port_c_dir)))
        else $error("port c pin source wrong");
    chk_t0_pulse: assert property (live && $past(cfg_e_q[0]) |-> port_e_pin_oe[0] &&
        port_e_pin_o[0] == ($past(timer0_split_mode) ? $past(timer0_low_overflow) : $past(timer0_overflow)))
        else $error("timer 0 overflow pin wrong");
    chk_t1_pulse: assert property (live && $past(cfg_e_q[1]) |-> port_e_pin_oe[1] &&
        port_e_pin_o[1] == ($past(timer1_split_mode) ? $past(timer1_low_overflow) : $past(timer1_overflow)))
        else $error("timer 1 overflow pin wrong");
    chk_bus_select: assert property (live |-> port_b_is_bus == ($past(interface_config_select) != 2'h0)
        && port_d_is_bus == (port_b_is_bus && $past(endpoint_fifo_config)))
        else $error("bus selection wrong");
    chk_bus_low: assert property (live && port_b_is_bus |-> port_b_pin_o == $past(bus_lo)
        && port_b_pin_oe == {8{$past(fifo_data_bus_drive)}})
        else $error("low bus byte not on port b");
    chk_tx_source: assert property (live |-> serial0_tx_pin ==
        ($past(serial0_sync_mode) ? $past(serial0_shift_clk) : $past(serial0_data_out)))
        else $error("transmit pin source wrong");
    chk_count_gate: assert property (!timer0_counter_timer_select [*4] |=> !timer0_count_tick)
        else $error("count tick while timer selected");
endmodule // port_pin_checker

bind port_pin_function_mux port_pin_checker chk_i (.*);

/* tb/pin_partner.sv */
// far-side pads sharing the port pins with the block
`timescale 1ns/1ns
module pin_partner #(
    parameter int W = 26
) (
    // clock
    input  logic         ref_clk,
    // block and far-side drives
    input  logic [W-1:0] dut_o, dut_oe, ext_v, ext_oe,
    // resolved pad level
    output logic [W-1:0] pin
);
    logic [W-1:0] last_q = '0;
    // a released pad flips every cycle so a stale value never passes
    always_comb begin
        for (int i = 0; i < W; i++)
            pin[i] = dut_oe[i] ? dut_o[i] : ext_oe[i] ? ext_v[i] : ~last_q[i];
    end
    // remember the level for the release pattern
    always_ff @(posedge ref_clk) begin
        last_q <= pin;
    end
endmodule // pin_partner

/* tb/tb.sv */
// self-checking bench for the port pin function multiplexer
`timescale 1ns/1ns
`include "port_pin_map.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("wrong value at %0t: %h want %h", $time, a, e); end end
module tb;
    logic [15:0] reg_addr, fifo_data_bus_out, fifo_data_bus_in;
    logic [7:0]  reg_wdata, reg_rdata, port_b_latch, port_b_dir, port_c_latch, port_c_dir,
                 port_d_latch, port_d_dir, waveform_address_out, port_b_pin_i, port_b_pin_o,
                 port_b_pin_oe, port_c_pin_i, port_c_pin_o, port_c_pin_oe, port_d_pin_i,
                 port_d_pin_o, port_d_pin_oe;
    logic [1:0]  interface_config_select, port_e_latch, port_e_dir, port_e_pin_i,
                 port_e_pin_o, port_e_pin_oe;
    logic        ref_clk, rst, reg_wr, reg_rd, endpoint_fifo_config, fifo_data_bus_drive,
                 timer0_overflow, timer0_low_overflow, timer0_split_mode, timer1_overflow,
                 timer1_low_overflow, timer1_split_mode, timer0_counter_timer_select,
                 timer1_counter_timer_select, timer0_count_tick, timer1_count_tick,
                 serial0_sync_mode, serial0_shift_clk, serial0_data_out, serial1_sync_mode,
                 serial1_shift_clk, serial1_data_out, serial0_rx_data, serial1_rx_data,
                 mem_cs_req, mem_wr_req, mem_rd_req, mem_oe_req, suspend_req, suspended,
                 osc_start, wakeup_irq, timer0_count_input, timer1_count_input,
                 serial0_rx_pin, serial1_rx_pin, wakeup_pin, serial0_tx_pin, serial1_tx_pin,
                 mem_cs_n, mem_wr_n, mem_rd_n, mem_oe_n, port_b_is_bus, port_d_is_bus;
    logic [25:0] ext_v, ext_oe;
    int          n_fail = 0, checks = 0;

    port_pin_function_mux DUT (.*);
    pin_partner #(.W(26)) far_end (.ref_clk, .ext_v, .ext_oe,
        .dut_o ({port_b_pin_o, port_c_pin_o, port_d_pin_o, port_e_pin_o}),
        .dut_oe({port_b_pin_oe, port_c_pin_oe, port_d_pin_oe, port_e_pin_oe}),
        .pin   ({port_b_pin_i, port_c_pin_i, port_d_pin_i, port_e_pin_i}));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    //==========================================================
    // bus cycles
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    // one overflow pulse, then the cycle after it
    task ovp(input logic [1:0] ov, lo, sp, e1, e2);
        @(posedge ref_clk);
        {timer1_overflow, timer0_overflow, timer1_low_overflow, timer0_low_overflow} <= {ov, lo};
        {timer1_split_mode, timer0_split_mode} <= sp;
        @(posedge ref_clk);
        {timer1_overflow, timer0_overflow, timer1_low_overflow, timer0_low_overflow} <= 4'h0;
        #1 `CHK(port_e_pin_o, e1)
        @(posedge ref_clk);
        #1 `CHK(port_e_pin_o, e2)
    endtask
    //==========================================================
    // scenarios
    task t_config;
        rd(`PORT_C_ALT_CONFIG_ADDR, `ALT_CONFIG_RESET);
        rd(`PORT_E_ALT_CONFIG_ADDR, `ALT_CONFIG_RESET);
        wr(`PORT_E_ALT_CONFIG_ADDR, 8'hfc);
        wr(16'he6ff, 8'h77);
        rd(16'he6ff, 8'h00);
        rd(`PORT_E_ALT_CONFIG_ADDR, 8'hfc);
        {port_c_latch, port_c_dir, waveform_address_out} <= {8'h3c, 8'h0f, 8'hc3};
        wr(`PORT_C_ALT_CONFIG_ADDR, 8'h5a);
        cyc(2);
        #1 `CHK(port_c_pin_o, 8'h5a & 8'hc3 | 8'ha5 & 8'h3c)
        `CHK(port_c_pin_oe, 8'h5f)
        rd(`PORT_C_ALT_CONFIG_ADDR, 8'h5a);
    endtask
    task t_porte;
        wr(`PORT_E_ALT_CONFIG_ADDR, 8'h03);
        ovp(2'b01, 2'b00, 2'b00, 2'b01, 2'b00);
        ovp(2'b10, 2'b00, 2'b00, 2'b10, 2'b00);
        ovp(2'b11, 2'b00, 2'b11, 2'b00, 2'b00);
        ovp(2'b00, 2'b11, 2'b11, 2'b11, 2'b00);
        `CHK(port_e_pin_oe, 2'b11)
        wr(`PORT_E_ALT_CONFIG_ADDR, 8'h00);
        {port_e_latch, port_e_dir} <= 4'b1001;
        ovp(2'b11, 2'b00, 2'b00, 2'b10, 2'b10);
    endtask
    task t_bus;
        {port_b_latch, port_d_latch, port_b_dir, port_d_dir} <= 32'h1122ffff;
        {fifo_data_bus_out, fifo_data_bus_drive} <= {16'ha55a, 1'b1};
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            {endpoint_fifo_config, interface_config_select} <= i[2:0];
            cyc(2);
            #1 `CHK(port_b_pin_o, i[1:0] != 0 ? 8'h5a : 8'h11)
            `CHK(port_d_pin_o, i[1:0] != 0 && i[2] ? 8'ha5 : 8'h22)
        end
        {ext_v, ext_oe, fifo_data_bus_drive} <= {26'h25801a4, 26'h3fc03fc, 1'b0};
        cyc(5);
        #1 `CHK(fifo_data_bus_in, 16'h6996)
        `CHK(port_b_pin_oe, 8'h00)
        `CHK(port_d_pin_oe, 8'h00)
        endpoint_fifo_config <= 1'b0;
        cyc(5);
        #1 `CHK(fifo_data_bus_in, 16'h0096)
        `CHK(port_d_pin_oe, 8'hff)
        {interface_config_select, ext_oe} <= '0;
    endtask
    task t_serial;
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            {serial0_sync_mode, serial0_shift_clk, serial0_data_out} <= k[2:0];
            {serial1_sync_mode, serial1_shift_clk, serial1_data_out} <= ~k[2:0];
            {serial0_rx_pin, serial1_rx_pin} <= k[1:0];
            cyc(4);
            #1 `CHK(serial0_tx_pin, k[2] ? k[1] : k[0])
            `CHK(serial1_tx_pin, !k[2] ? !k[1] : !k[0])
            `CHK({serial0_rx_data, serial1_rx_data}, k[1:0])
        end
    endtask
    task t_count_mem;
        int n0, n1;
        for (int s = 0; s < 2; s++) begin
            {n0, n1} = '0;
            {timer0_counter_timer_select, timer1_counter_timer_select} <= {s[0], !s[0]};
            for (int c = 0; c < 32; c++) begin
                @(posedge ref_clk);
                {timer0_count_input, timer1_count_input} <= {2{c[2] && c < 24}};
                #1 n0 += timer0_count_tick;
                n1 += timer1_count_tick;
            end
            `CHK(n0, 3 * s)
            `CHK(n1, 3 - 3 * s)
        end
        for (int k = 0; k < 17; k++) begin
            @(posedge ref_clk);
            {mem_cs_req, mem_wr_req, mem_rd_req, mem_oe_req} <= k[3:0];
            cyc(2);
            #1 `CHK({mem_cs_n, mem_wr_n, mem_rd_n, mem_oe_n}, ~k[3:0])
        end
    endtask
    task t_wake;
        int n_osc, n_irq;
        {n_osc, n_irq} = '0;
        suspend_req <= 1'b1;
        cyc(6);
        #1 `CHK(suspended, 1'b1)
        wakeup_pin <= 1'b0;
        repeat (10) begin
            @(posedge ref_clk);
            #1 n_osc += osc_start;
            n_irq += wakeup_irq;
        end
        `CHK(n_osc > 0 && n_irq > 0 && suspended === 1'b0, 1'b1)
        wr(`WAKEUP_CTRL_ADDR, 8'h10);
        cyc(6);
        #1 `CHK(suspended, 1'b1)
        wakeup_pin <= 1'b1;
        cyc(8);
        #1 `CHK(suspended, 1'b0)
        wr(`PIN_STATUS_ADDR, 8'hff);
        rd(`PIN_STATUS_ADDR, 8'h04);
        suspend_req <= 1'b0;
    endtask
    //==========================================================
    // verdict
    task final_report;
        $display("comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence; strobes are looked at in reset before release
    initial begin
        {reg_addr, fifo_data_bus_out, reg_wdata, port_b_latch, port_b_dir, port_c_latch,
         port_c_dir, port_d_latch, port_d_dir, waveform_address_out, port_e_latch,
         interface_config_select, port_e_dir, ext_v, ext_oe} = '0;
        {reg_wr, reg_rd, endpoint_fifo_config, fifo_data_bus_drive, timer0_overflow,
         timer0_low_overflow, timer0_split_mode, timer1_overflow, timer1_low_overflow,
         timer1_split_mode, timer0_counter_timer_select, timer1_counter_timer_select,
         serial0_sync_mode, serial0_shift_clk, serial0_data_out, serial1_sync_mode,
         serial1_shift_clk, serial1_data_out, mem_cs_req, mem_wr_req, mem_rd_req, mem_oe_req,
         suspend_req, timer0_count_input, timer1_count_input, serial0_rx_pin,
         serial1_rx_pin} = '0;
        {wakeup_pin, rst} = 2'b11;
        cyc(19);
        #1 `CHK({mem_cs_n, mem_wr_n, mem_rd_n, mem_oe_n}, 4'hf)
        @(posedge ref_clk);
        rst <= 1'b0;
        t_config;
        t_porte;
        t_bus;
        t_serial;
        t_count_mem;
        t_wake;
        final_report;
    end
    // hang guard, several times the expected run
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        final_report;
    end
endmodule // tb
